// ==== core/bau_core.sv ====
// Breakpoint acknowledge unit: register pairs and acknowledge cycle answer
`timescale 1ns/10ps
module bau_core #(
  parameter int PAIRS = bau_pkg::NUM_PAIRS,
  parameter int OPC_W = bau_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire bau_pkg::bau_host_req_t hostReq,
  output bau_pkg::bau_host_rsp_t hostRsp,
  input wire bau_pkg::bau_reg_req_t regReq,
  output logic [bau_pkg::DATA_W-1:0] regRdata,
  output logic busy
);
  import bau_pkg::*;

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  initial begin
    if (PAIRS != NUM_PAIRS || OPC_W != DATA_W) begin
      $error("bau_core: only eight 16-bit pairs are supported");
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [DATA_W-1:0] ctl_word(
    input logic en,
    input logic [CTL_COUNT_W-1:0] cnt
  );
    logic [DATA_W-1:0] w;
    w = '0;
    w[CTL_ENABLE_BIT] = en;
    w[CTL_COUNT_LSB +: CTL_COUNT_W] = cnt;
    ctl_word = w;
  endfunction : ctl_word

  function automatic logic is_bkpt_ack(input bau_host_req_t r);
    is_bkpt_ack = r.start && r.read && (r.functionCode == FC_CPU_SPACE)
      && (r.addr[SPACE_TYPE_LSB +: 4] == SPACE_BKPT_ACK);
  endfunction : is_bkpt_ack

  // ==========================================================
  // Pair storage
  // ==========================================================
  logic [DATA_W-1:0] opcode_ff [NUM_PAIRS];
  logic [DATA_W-1:0] nxt_opcode [NUM_PAIRS];
  logic enable_ff [NUM_PAIRS];
  logic nxt_enable [NUM_PAIRS];
  logic [CTL_COUNT_W-1:0] count_ff [NUM_PAIRS];
  logic [CTL_COUNT_W-1:0] nxt_count [NUM_PAIRS];

  bau_state_t state_ff;
  bau_state_t nxt_state;
  bau_host_rsp_t rsp_ff;
  bau_host_rsp_t nxt_rsp;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  logic ackHit;
  logic [SEL_W-1:0] bkptNum;
  logic [SEL_W-1:0] regPair;
  logic regIsCtl;

  // only the encoded fields are looked at
  assign ackHit = is_bkpt_ack(hostReq);
  assign bkptNum = hostReq.addr[BKPT_NUM_LSB +: SEL_W];
  assign regPair = regReq.index[SEL_W-1:0];
  assign regIsCtl = regReq.index[REG_IDX_W-1];

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    nxt_opcode = opcode_ff;
    nxt_enable = enable_ff;
    nxt_count = count_ff;
    nxt_state = BAU_IDLE;
    nxt_rsp = '0;
    nxt_rdata = rdata_ff;

    if (ackHit) begin
      nxt_state = BAU_ANSWER;
      if (enable_ff[bkptNum] && count_ff[bkptNum] != '0) begin
        nxt_rsp.transferAck = 1'b1;
        nxt_rsp.data = opcode_ff[bkptNum];
        nxt_count[bkptNum] = count_ff[bkptNum] - 8'h01;
      end else begin
        nxt_rsp.busError = 1'b1;
      end
    end

    // Software write after the decrement: a fresh load is never eaten
    if (regReq.wrEn) begin
      if (regIsCtl) begin
        nxt_enable[regPair] = regReq.wdata[CTL_ENABLE_BIT];
        nxt_count[regPair] = regReq.wdata[CTL_COUNT_LSB +: CTL_COUNT_W];
      end else begin
        nxt_opcode[regPair] = regReq.wdata;
      end
    end

    if (regReq.rdEn) begin
      if (regIsCtl) begin
        nxt_rdata = ctl_word(enable_ff[regPair], count_ff[regPair]);
      end else begin
        nxt_rdata = opcode_ff[regPair];
      end
    end

    case (state_ff)
      BAU_IDLE: begin
      end
      BAU_ANSWER: begin
      end
      default: begin
        nxt_state = BAU_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= BAU_IDLE;
      rsp_ff <= '0;
      rdata_ff <= '0;
      for (int i = 0; i < NUM_PAIRS; i++) begin
        // enables only; counts and opcodes kept
        enable_ff[i] <= CTL_ENABLE_RST;
      end
    end else if (clkEn) begin
      state_ff <= nxt_state;
      rsp_ff <= nxt_rsp;
      rdata_ff <= nxt_rdata;
      enable_ff <= nxt_enable;
    end
  end

  // Not reset on purpose: contents survive reset
  always_ff @(posedge sys_clk) begin
    if (clkEn && !srst) begin
      opcode_ff <= nxt_opcode;
      count_ff <= nxt_count;
    end
  end

  assign hostRsp = rsp_ff;
  assign regRdata = rdata_ff;
  assign busy = (state_ff == BAU_ANSWER);

endmodule : bau_core

// ==== core/bau_pkg.sv ====
// Package for the breakpoint acknowledge unit: constants and carriers
package bau_pkg;

  // ==========================================================
  // Pair layout and opcode range
  // ==========================================================
  localparam int NUM_PAIRS = 8;
  localparam int SEL_W = 3;
  localparam int DATA_W = 16;
  localparam logic [15:0] BKPT_OPCODE_BASE = 16'h4848;
  localparam logic [15:0] BKPT_OPCODE_LAST = 16'h484f;

  // ==========================================================
  // Control register fields
  // ==========================================================
  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_COUNT_LSB = 0;
  localparam int CTL_COUNT_W = 8;
  localparam logic CTL_ENABLE_RST = 1'b0;

  // ==========================================================
  // Register move port: index 0..7 opcodes, 8..15 controls
  // ==========================================================
  localparam int REG_IDX_W = 4;
  localparam logic [3:0] REG_IDX_OPCODE0 = 4'h0;
  localparam logic [3:0] REG_IDX_CONTROL0 = 4'h8;

  // ==========================================================
  // Host cycle decode
  // ==========================================================
  localparam logic [3:0] FC_CPU_SPACE = 4'h7;
  localparam int SPACE_TYPE_LSB = 16;
  localparam logic [3:0] SPACE_BKPT_ACK = 4'h0;
  localparam int BKPT_NUM_LSB = 2;
  localparam int ADDR_W = 20;

  typedef struct packed {
    logic start;
    logic read;
    logic [3:0] functionCode;
    logic [ADDR_W-1:0] addr;
  } bau_host_req_t;

  typedef struct packed {
    logic transferAck;
    logic busError;
    logic [DATA_W-1:0] data;
  } bau_host_rsp_t;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [REG_IDX_W-1:0] index;
    logic [DATA_W-1:0] wdata;
  } bau_reg_req_t;

  typedef enum logic [1:0] {
    BAU_IDLE = 2'b01,
    BAU_ANSWER = 2'b10
  } bau_state_t;

endpackage : bau_pkg

// ==== sim/bau_host_model.sv ====
// Host model issuing breakpoint acknowledge reads
`timescale 1ns/10ps
module bau_host_model (
  input wire logic sys_clk,
  input wire bau_pkg::bau_host_rsp_t hostRsp,
  output bau_pkg::bau_host_req_t hostReq
);
  import bau_pkg::*;
  logic [7:0] vector;
  initial hostReq = '0;
  task automatic cycle(logic [3:0] fc, logic [3:0] sp, logic [2:0] n,
    output bau_host_rsp_t r);
    @(posedge sys_clk);
    hostReq <= '{1'b1, 1'b1, fc, {sp, 11'h0, n, 2'b0}};
    @(posedge sys_clk);
    // Released lines show the inverse, not the last value
    hostReq <= '{1'b0, 1'b0, ~fc, ~{sp, 11'h0, n, 2'b0}};
    #1 r = hostRsp;
    vector = r.busError ? 8'h04 : 8'h00;
  endtask : cycle
endmodule : bau_host_model

// ==== sim/bau_core_asserts.sv ====
// Port assertions for the breakpoint acknowledge unit
`timescale 1ns/10ps
module bau_core_asserts (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire bau_pkg::bau_host_req_t hostReq,
  input wire bau_pkg::bau_host_rsp_t hostRsp,
  input wire bau_pkg::bau_reg_req_t regReq,
  input wire logic [bau_pkg::DATA_W-1:0] regRdata,
  input wire logic busy
);
  import bau_pkg::*;
  logic [15:0] opc_ff [8];
  logic [15:0] want_ff;
  wire take = clkEn && hostReq.start && hostReq.read &&
    hostReq.functionCode == FC_CPU_SPACE && hostReq.addr[19:16] == 4'h0;
  wire ans = hostRsp.transferAck || hostRsp.busError;
  // Shadow of opcode writes, picked at the taking edge
  always_ff @(posedge sys_clk) begin
    if (clkEn && regReq.wrEn && !regReq.index[3])
      opc_ff[regReq.index[2:0]] <= regReq.wdata;
    want_ff <= opc_ff[hostReq.addr[4:2]];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_answer_next:
    assert property (take |=> hostRsp.transferAck ^ hostRsp.busError)
    else $error("no single answer after acknowledge");
  a_no_stray:
    assert property (ans |-> $past(take))
    else $error("answer without acknowledge cycle");
  a_data_idle:
    assert property (!hostRsp.transferAck |-> hostRsp.data == 16'h0)
    else $error("data driven without acknowledge");
  a_busy_single:
    assert property (busy |-> hostRsp.transferAck ^ hostRsp.busError)
    else $error("busy without single ending");
  a_ack_opcode:
    assert property (hostRsp.transferAck |-> hostRsp.data == want_ff)
    else $error("wrong replacement word");
  a_ctl_zero:
    assert property ($past(regReq.rdEn && regReq.index[3])
      |-> regRdata[14:8] == 7'h0)
    else $error("control unused bits not zero");
  a_opc_readback:
    assert property (regReq.wrEn && !regReq.index[3] ##1 regReq.rdEn &&
      regReq.index == $past(regReq.index)
      |=> regRdata == $past(regReq.wdata, 2))
    else $error("opcode readback differs");
  a_reset_quiet:
    assert property ($past(srst) |-> !busy && !ans && regRdata == 16'h0)
    else $error("outputs not cleared by reset");
endmodule : bau_core_asserts
bind bau_core bau_core_asserts chk_u (.sys_clk(sys_clk), .srst(srst),
  .clkEn(clkEn), .hostReq(hostReq), .hostRsp(hostRsp),
  .regReq(regReq), .regRdata(regRdata), .busy(busy));

// ==== sim/bau_core_bench.sv ====
// Self-checking bench for the breakpoint acknowledge unit
`timescale 1ns/10ps
module bau_core_bench;
  import bau_pkg::*;
  logic sys_clk = 0;
  logic srst = 1;
  logic clkEn = 1;
  bau_host_req_t hostReq;
  bau_host_rsp_t hostRsp;
  bau_reg_req_t regReq = '0;
  logic [15:0] regRdata;
  logic busy;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  bau_core dut_u (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .hostReq(hostReq), .hostRsp(hostRsp), .regReq(regReq),
    .regRdata(regRdata), .busy(busy));
  bau_host_model host_u (.sys_clk(sys_clk), .hostRsp(hostRsp),
    .hostReq(hostReq));
  initial forever #20 sys_clk = ~sys_clk;
  task automatic summarize;
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(string s, logic [17:0] e, logic [17:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr(logic [3:0] i, logic [15:0] d);
    @(posedge sys_clk);
    regReq <= '{1'b1, 1'b0, i, d};
    @(posedge sys_clk);
    regReq <= '0;
  endtask : wr
  task automatic rd(logic [3:0] i, logic [15:0] e);
    @(posedge sys_clk);
    regReq <= '{1'b0, 1'b1, i, 16'h0};
    @(posedge sys_clk);
    regReq <= '0;
    #1 chk("reg", {2'b0, e}, {2'b0, regRdata});
  endtask : rd
  task automatic ack(logic [2:0] n, logic [17:0] e,
    logic [3:0] fc = 4'h7, logic [3:0] sp = 4'h0);
    bau_host_rsp_t r;
    host_u.cycle(fc, sp, n, r);
    chk("host", e, {r.transferAck, r.busError, r.data});
    chk("vector", {10'h0, (e[16] ? 8'h04 : 8'h00)}, {10'h0, host_u.vector});
  endtask : ack
  task automatic t_b2b;
    @(posedge sys_clk);
    regReq <= '{1'b1, 1'b0, 4'h3, 16'hc3e1};
    @(posedge sys_clk);
    regReq <= '{1'b0, 1'b1, 4'h3, 16'h0};
    @(posedge sys_clk);
    regReq <= '0;
    #1 chk("reg", {2'b0, 16'hc3e1}, {2'b0, regRdata});
  endtask : t_b2b
  task automatic t_freeze;
    // Frozen clock enable: the write must not land
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(4'h8, 16'h8005);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    rd(4'h8, 16'h8000);
  endtask : t_freeze
  task automatic t_ctl_reset;
    wr(4'h8, 16'h80ff);
    rd(4'h8, 16'h80ff);
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    rd(4'h8, 16'h00ff);
    ack(3'h0, 18'h10000);
    rd(4'h8, 16'h00ff);
  endtask : t_ctl_reset
  task automatic t_pairs;
    for (int n = 0; n < 8; n++) begin
      wr(4'(n), {4'(n), 12'h5a3});
      rd(4'(n), {4'(n), 12'h5a3});
      wr(4'(8 + n), 16'h8002);
      ack(3'(n), {2'b10, 4'(n), 12'h5a3});
      ack(3'(n), {2'b10, 4'(n), 12'h5a3});
      ack(3'(n), 18'h10000);
      rd(4'(8 + n), 16'h8000);
    end
  endtask : t_pairs
  task automatic t_decode;
    ack(3'h0, 18'h0, 4'h5, 4'h0);
    ack(3'h0, 18'h0, 4'h7, 4'h1);
  endtask : t_decode
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    t_ctl_reset();
    t_pairs();
    t_freeze();
    t_b2b();
    t_decode();
    summarize();
  end
endmodule : bau_core_bench
